// [src/mqfbp_defines.svh]
`ifndef MQFBP_DEFINES_SVH
`define MQFBP_DEFINES_SVH
// ==========================================================
// Register map (byte addresses on the Wishbone slave)
`define MQFBP_ADR_CTRL   8'h00
`define MQFBP_ADR_STAT   8'h04
`define MQFBP_ADR_OFF0   8'h20
`define MQFBP_ADR_OFF7   8'h3c
// ==========================================================
// Fields and reset values
`define MQFBP_CTRL_PKT   4
`define MQFBP_QCNT_RST   4'h8
`define MQFBP_OFF_LOW    8'h08
`define MQFBP_OFF_HIGH   8'h80
// ==========================================================
// Queue geometry
`define MQFBP_QDEPTH     9'h100
`define MQFBP_NQ         8
`endif

// [src/mqfbp_pkg.sv]
package mqfbp_pkg;
  // Port width codes, Gray along x36 -> x18 -> x9
  typedef enum logic [1:0] {
    MQFBP_X36 = 2'b00,
    MQFBP_X18 = 2'b01,
    MQFBP_X9  = 2'b11
  } mqfbp_width_type;
  // One status flag bus as seen at the pins
  typedef struct packed {
    logic [7:0] flags_n;
    logic       oe;
    logic       sync;
  } mqfbp_flag_bus_type;
  // Device and queue address of a port
  typedef struct packed {
    logic [2:0] dev;
    logic [2:0] queue;
  } mqfbp_qaddr_type;
  // Data word with packet markers in the top bits
  typedef struct packed {
    logic        eop;
    logic        sop;
    logic [33:0] data;
  } mqfbp_word_type;
endpackage

// [src/mqfbp_top.sv]
`timescale 1ns/100ps
`include "mqfbp_defines.svh"
// Overview of operation
// RULE1 - Drive separate 8-bit almost-full and almost-empty status buses.
// RULE2 - Keep programmable almost-full and almost-empty offsets per queue.
// RULE3 - Bus bits beyond configured queue count stay inactive.
// RULE4 - Polled mode shows each chained device in turn, one per edge.
// RULE5 - Polled almost-full follows write side, almost-empty follows read side.
// RULE6 - Direct mode: outside party selects each bus's driver independently.
// RULE7 - Full bus selected through write port, empty bus through read port.
// RULE8 - Packet mode only when both ports are 36 bits wide.
// RULE9 - Bit 34 marks first packet word, bit 35 marks last.
// RULE10 - Packets of any length are accepted.
// RULE11 - Count end markers; packet ready with output valid shows a whole packet.
// RULE12 - In packet mode almost-empty bits report per-queue packet ready.
// RULE13 - Up to eight devices in parallel, at most 64 queues.
// RULE14 - Flag buses may stay separate or be shared between devices.
// RULE15 - System wires inputs and outputs of expanded devices together.
// RULE16 - Width selects are set before reset and held stable.
// RULE17 - Write 36-bit word into selected queue while write enable is low.
// RULE18 - Writer holds unused narrow-width data inputs low.
// RULE19 - Default offsets are 8 or 128 from the strap at reset.
// RULE20 - Flag-mode strap at reset: high polled, low direct.
// RULE21 - Empty bus sync is high while own status is on the bus; the code raises it in polled mode only, never in direct mode.
// RULE22 - Each port is 9, 18 or 36 bits, at least one 36.
// RULE23 - Status bits are active low, asserted when threshold is crossed.
module mqfbp_top (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic [7:0]                   adr_i,
  input  wire logic [31:0]                  dat_i,
  output logic      [31:0]                  dat_o,
  input  wire logic                         we_i,
  input  wire logic [3:0]                   sel_i,
  input  wire logic                         cyc_i,
  input  wire logic                         stb_i,
  output logic                              ack_o,
  input  wire logic                         bus_width_select_i,
  input  wire logic                         input_width_select_i,
  input  wire logic                         output_width_select_i,
  input  wire logic                         default_offset_select_i,
  input  wire logic                         flag_bus_mode_select_i,
  input  wire logic [2:0]                   device_id_i,
  input  wire mqfbp_pkg::mqfbp_qaddr_type   wradd_i,
  input  wire logic                         waden_i,
  input  wire logic                         fstr_i,
  input  wire logic                         wen_n_i,
  input  wire mqfbp_pkg::mqfbp_word_type    din_i,
  output logic                              full_flag_n_o,
  input  wire logic                         full_bus_token_i,
  output logic                              full_bus_token_o,
  input  wire mqfbp_pkg::mqfbp_qaddr_type   rdadd_i,
  input  wire logic                         raden_i,
  input  wire logic                         estr_i,
  input  wire logic                         ren_n_i,
  output mqfbp_pkg::mqfbp_word_type         dout_o,
  output logic                              output_valid_flag_n_o,
  output logic                              packet_ready_flag_n_o,
  input  wire logic                         empty_bus_token_i,
  output logic                              empty_bus_token_o,
  output mqfbp_pkg::mqfbp_flag_bus_type     almost_full_status_bus_o,
  output mqfbp_pkg::mqfbp_flag_bus_type     almost_empty_status_bus_o
);
  import mqfbp_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [35:0] width_mask(input mqfbp_width_type w);
    unique case (w)
      MQFBP_X36: width_mask = 36'hfffffffff;
      MQFBP_X18: width_mask = 36'h00003ffff;
      MQFBP_X9:  width_mask = 36'h0000001ff;
      default:   width_mask = 36'hfffffffff;
    endcase
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] sel);
    lane_merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        lane_merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  // ==========================================================
  // State
  mqfbp_width_type   iw_q, iw_d, ow_q, ow_d;
  logic              polled_q, polled_d;
  logic [2:0]        dev_q, dev_d;
  logic [3:0]        qcnt_q, qcnt_d;
  logic              pkt_en_q, pkt_en_d;
  logic [15:0]       off_q [8];
  logic [15:0]       off_d [8];
  logic [8:0]        lvl_q [8];
  logic [8:0]        lvl_d [8];
  logic [8:0]        pcnt_q [8];
  logic [8:0]        pcnt_d [8];
  logic [7:0]        wp_q [8];
  logic [7:0]        wp_d [8];
  logic [7:0]        rp_q [8];
  logic [7:0]        rp_d [8];
  logic [35:0]       mem_q [2048];
  logic [2:0]        wq_q, wq_d, rq_q, rq_d;
  logic              wown_q, wown_d, rown_q, rown_d;
  logic              tokf_q, tokf_d, toke_q, toke_d;
  logic              self_q, self_d, sele_q, sele_d;
  logic              ack_q, ack_d;
  logic [31:0]       dat_q, dat_d;
  mqfbp_word_type    dout_q, dout_d;
  logic              ov_n_q, ov_n_d, pr_n_q, pr_n_d, ff_n_q, ff_n_d;
  mqfbp_flag_bus_type afb_q, afb_d, aeb_q, aeb_d;
  logic              pkt_q, wr, rd, wb_wr;
  logic [35:0]       rd_word;
  logic [7:0]        af_n, ae_n, pr_bits;

  assign pkt_q = pkt_en_q && iw_q == MQFBP_X36 && ow_q == MQFBP_X36; // [RULE8]
  // Full queue blocks the write; the word is masked to the input width
  assign wr = !wen_n_i && wown_q && lvl_q[wq_q] != `MQFBP_QDEPTH; // [RULE17] [RULE10]
  assign rd = !ren_n_i && rown_q && lvl_q[rq_q] != 9'h000;
  assign rd_word = mem_q[{rq_q, rp_q[rq_q]}];
  assign wb_wr = cyc_i && stb_i && we_i && ack_q;

  // ==========================================================
  // Straps are caught while reset is high and then frozen
  always_comb begin
    iw_d = iw_q;
    ow_d = ow_q;
    polled_d = polled_q;
    dev_d = dev_q;
    if (rst_i) begin
      polled_d = flag_bus_mode_select_i; // [RULE20]
      dev_d = device_id_i; // [RULE13]
      iw_d = MQFBP_X36;
      ow_d = MQFBP_X36;
      // A narrow port always pairs with a x36 partner
      if (bus_width_select_i) begin // [RULE22] [RULE16]
        unique case ({input_width_select_i, output_width_select_i})
          2'b00: ow_d = MQFBP_X18;
          2'b01: ow_d = MQFBP_X9;
          2'b10: iw_d = MQFBP_X18;
          2'b11: iw_d = MQFBP_X9;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    iw_q <= iw_d;
    ow_q <= ow_d;
    polled_q <= polled_d;
    dev_q <= dev_d;
  end

  // ==========================================================
  // Wishbone slave: one wait state, commit on the acked edge
  always_comb begin
    ack_d = cyc_i && stb_i && !ack_q;
    dat_d = 32'h00000000;
    qcnt_d = qcnt_q;
    pkt_en_d = pkt_en_q;
    for (int q = 0; q < 8; q++) begin
      off_d[q] = off_q[q];
    end
    if (ack_d && !we_i) begin
      if (adr_i == `MQFBP_ADR_CTRL) begin
        dat_d = {27'h0000000, pkt_en_q, qcnt_q};
      end else if (adr_i == `MQFBP_ADR_STAT) begin
        dat_d = {6'h00, polled_q, pkt_q, pr_bits, aeb_q.flags_n, afb_q.flags_n};
      end else if (adr_i >= `MQFBP_ADR_OFF0 && adr_i <= `MQFBP_ADR_OFF7
                   && adr_i[1:0] == 2'b00) begin
        dat_d = {16'h0000, off_q[adr_i[4:2]]};
      end
    end
    if (wb_wr && adr_i == `MQFBP_ADR_CTRL && sel_i[0]) begin
      qcnt_d = dat_i[3:0];
      pkt_en_d = dat_i[`MQFBP_CTRL_PKT];
    end
    if (wb_wr && adr_i >= `MQFBP_ADR_OFF0 && adr_i <= `MQFBP_ADR_OFF7
        && adr_i[1:0] == 2'b00) begin
      off_d[adr_i[4:2]] = 16'(lane_merge({16'h0000, off_q[adr_i[4:2]]},
                                         dat_i, sel_i)); // [RULE2]
    end
    if (rst_i) begin
      ack_d = 1'b0;
      dat_d = 32'h00000000;
      qcnt_d = `MQFBP_QCNT_RST;
      pkt_en_d = 1'b0;
      for (int q = 0; q < 8; q++) begin
        off_d[q] = default_offset_select_i ? {2{`MQFBP_OFF_HIGH}}
                                           : {2{`MQFBP_OFF_LOW}}; // [RULE19]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    ack_q <= ack_d;
    dat_q <= dat_d;
    qcnt_q <= qcnt_d;
    pkt_en_q <= pkt_en_d;
    off_q <= off_d;
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ==========================================================
  // Queue storage; data memory carries no reset
  always_ff @(posedge clk_i) begin
    if (wr) begin
      mem_q[{wq_q, wp_q[wq_q]}] <= din_i & width_mask(iw_q); // [RULE17] [RULE18]
    end
  end

  // Levels, pointers and complete-packet counts
  always_comb begin
    for (int q = 0; q < 8; q++) begin
      lvl_d[q] = lvl_q[q];
      pcnt_d[q] = pcnt_q[q];
      wp_d[q] = wp_q[q];
      rp_d[q] = rp_q[q];
    end
    if (wr) begin
      wp_d[wq_q] = wp_q[wq_q] + 8'h01;
      lvl_d[wq_q] = lvl_d[wq_q] + 9'h001;
      if (pkt_q && din_i.eop) begin // [RULE9] [RULE11]
        pcnt_d[wq_q] = pcnt_d[wq_q] + 9'h001;
      end
    end
    if (rd) begin
      rp_d[rq_q] = rp_q[rq_q] + 8'h01;
      lvl_d[rq_q] = lvl_d[rq_q] - 9'h001;
      if (pkt_q && rd_word[35] && pcnt_d[rq_q] != 9'h000) begin // [RULE11]
        pcnt_d[rq_q] = pcnt_d[rq_q] - 9'h001;
      end
    end
    if (rst_i) begin
      for (int q = 0; q < 8; q++) begin
        lvl_d[q] = 9'h000;
        pcnt_d[q] = 9'h000;
        wp_d[q] = 8'h00;
        rp_d[q] = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    lvl_q <= lvl_d;
    pcnt_q <= pcnt_d;
    wp_q <= wp_d;
    rp_q <= rp_d;
  end

  // ==========================================================
  // Port selection, polled tokens and direct strobes
  always_comb begin
    wq_d = wq_q;
    wown_d = wown_q;
    rq_d = rq_q;
    rown_d = rown_q;
    if (waden_i) begin
      wq_d = wradd_i.queue;
      wown_d = wradd_i.dev == dev_q;
    end
    if (raden_i) begin
      rq_d = rdadd_i.queue;
      rown_d = rdadd_i.dev == dev_q;
    end
    // Token arrives one edge before this device owns the bus
    tokf_d = polled_q && full_bus_token_i; // [RULE4] [RULE5]
    toke_d = polled_q && empty_bus_token_i; // [RULE4] [RULE5]
    self_d = self_q;
    sele_d = sele_q;
    if (!polled_q && fstr_i) begin
      self_d = wradd_i.dev == dev_q; // [RULE6] [RULE7]
    end
    if (!polled_q && estr_i) begin
      sele_d = rdadd_i.dev == dev_q; // [RULE6] [RULE7]
    end
    if (rst_i) begin
      wq_d = 3'h0;
      rq_d = 3'h0;
      wown_d = 1'b0;
      rown_d = 1'b0;
      // Device zero starts the polling chain
      tokf_d = flag_bus_mode_select_i && device_id_i == 3'h0;
      toke_d = flag_bus_mode_select_i && device_id_i == 3'h0;
      self_d = 1'b0;
      sele_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    wq_q <= wq_d;
    wown_q <= wown_d;
    rq_q <= rq_d;
    rown_q <= rown_d;
    tokf_q <= tokf_d;
    toke_q <= toke_d;
    self_q <= self_d;
    sele_q <= sele_d;
  end

  // ==========================================================
  // Per-queue status, active low; unused queues read inactive
  always_comb begin
    for (int q = 0; q < 8; q++) begin
      pr_bits[q] = pkt_q && pcnt_q[q] != 9'h000;
      af_n[q] = 1'b1;
      ae_n[q] = 1'b1;
      if (q < int'(qcnt_q)) begin // [RULE3]
        af_n[q] = !(lvl_q[q] + {1'b0, off_q[q][7:0]} >= `MQFBP_QDEPTH); // [RULE23]
        ae_n[q] = pkt_q ? !pr_bits[q]
                        : !(lvl_q[q] <= {1'b0, off_q[q][15:8]}); // [RULE12] [RULE23]
      end
    end
  end

  // Bus, read-port and full-flag outputs, all registered
  always_comb begin
    afb_d.flags_n = af_n; // [RULE1] [RULE14]
    afb_d.oe = polled_q ? tokf_d : self_d;
    afb_d.sync = polled_q && tokf_d;
    aeb_d.flags_n = ae_n; // [RULE1] [RULE14]
    aeb_d.oe = polled_q ? toke_d : sele_d;
    aeb_d.sync = polled_q && toke_d; // [RULE21]
    dout_d = rd ? mqfbp_word_type'(rd_word & width_mask(ow_q)) : dout_q;
    ov_n_d = !rd;
    pr_n_d = !(pkt_q && pcnt_d[rq_d] != 9'h000); // [RULE11]
    ff_n_d = !(wown_d && lvl_d[wq_d] == `MQFBP_QDEPTH);
    if (rst_i) begin
      afb_d = '{flags_n: 8'hff, oe: 1'b0, sync: 1'b0};
      aeb_d = '{flags_n: 8'hff, oe: 1'b0, sync: 1'b0};
      dout_d = '0;
      ov_n_d = 1'b1;
      pr_n_d = 1'b1;
      ff_n_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    afb_q <= afb_d;
    aeb_q <= aeb_d;
    dout_q <= dout_d;
    ov_n_q <= ov_n_d;
    pr_n_q <= pr_n_d;
    ff_n_q <= ff_n_d;
  end

  assign almost_full_status_bus_o = afb_q;
  assign almost_empty_status_bus_o = aeb_q;
  assign full_bus_token_o = tokf_q;
  assign empty_bus_token_o = toke_q;
  assign dout_o = dout_q;
  assign output_valid_flag_n_o = ov_n_q;
  assign packet_ready_flag_n_o = pr_n_q;
  assign full_flag_n_o = ff_n_q;

  // ==========================================================
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_empty_sync_own: assert property (empty_bus_token_i && polled_q |=> // [RULE21]
    almost_empty_status_bus_o.sync && almost_empty_status_bus_o.oe && empty_bus_token_o)
    else $error("empty bus sync missing");
  a_full_poll_step: assert property (polled_q && !full_bus_token_i |=> // [RULE4]
    !almost_full_status_bus_o.oe && !full_bus_token_o)
    else $error("full bus driven without token");
  a_empty_dsel: assert property (!polled_q && estr_i && rdadd_i.dev == dev_q |=> // [RULE7]
    almost_empty_status_bus_o.oe)
    else $error("empty bus direct select lost");
  a_full_dsel_off: assert property (!polled_q && fstr_i && wradd_i.dev != dev_q |=> // [RULE6]
    !almost_full_status_bus_o.oe)
    else $error("full bus kept by other address");
  a_unused_bit_off: assert property (qcnt_q <= 4'h7 && $stable(qcnt_q) |=> // [RULE3]
    almost_full_status_bus_o.flags_n[7] && almost_empty_status_bus_o.flags_n[7])
    else $error("unconfigured queue bit active");
  a_pkt_x36_only: assert property (iw_q != MQFBP_X36 || ow_q != MQFBP_X36 |-> // [RULE8]
    !pkt_q ##1 packet_ready_flag_n_o)
    else $error("packet mode with narrow port");
  a_pkt_ready_set: assert property (pkt_q && wr && din_i.eop && wq_q == rq_q // [RULE11]
    && !raden_i |=> !packet_ready_flag_n_o)
    else $error("packet ready not raised");
  a_default_offs: assert property ($fell(rst_i) |-> off_q[3][7:0] == // [RULE19]
    ($past(default_offset_select_i) ? `MQFBP_OFF_HIGH : `MQFBP_OFF_LOW))
    else $error("default offset wrong");
  a_full_no_write: assert property (lvl_q[wq_q] == `MQFBP_QDEPTH && !rd |=> // [RULE17]
    lvl_q[$past(wq_q)] == `MQFBP_QDEPTH)
    else $error("full queue overwritten");

  c_polled_sync: cover property (polled_q ##1 almost_empty_status_bus_o.sync);
  c_pkt_ready: cover property (pkt_q ##1 !packet_ready_flag_n_o);
  c_wb_write: cover property (wb_wr);
  c_full_flag: cover property (!full_flag_n_o);
endmodule

// [testbench/mqfbp_far_end.sv]
`timescale 1ns/100ps
// ==========================================================
// Far-side writer and reader model
module mqfbp_far_end (
  input  wire logic                       clk_i,
  output mqfbp_pkg::mqfbp_qaddr_type      wradd_o,
  output logic                            waden_o,
  output logic                            fstr_o,
  output logic                            wen_n_o,
  output mqfbp_pkg::mqfbp_word_type       din_o,
  output mqfbp_pkg::mqfbp_qaddr_type      rdadd_o,
  output logic                            raden_o,
  output logic                            estr_o,
  output logic                            ren_n_o,
  input  wire mqfbp_pkg::mqfbp_word_type  dout_i,
  input  wire logic                       ov_n_i
);
  import mqfbp_pkg::*;
  // Idle levels at time zero, enables inactive
  initial begin
    wradd_o = '0;
    waden_o = 1'b0;
    fstr_o  = 1'b0;
    wen_n_o = 1'b1;
    din_o   = '0;
    rdadd_o = '0;
    raden_o = 1'b0;
    estr_o  = 1'b0;
    ren_n_o = 1'b1;
  end
  // Write-port address cycle: queue select or full-bus device select
  task automatic sel_w(input logic [5:0] a, input logic strobe);
    @(posedge clk_i);
    wradd_o <= a;
    waden_o <= ~strobe;
    fstr_o  <= strobe;
    @(posedge clk_i);
    waden_o <= 1'b0;
    fstr_o  <= 1'b0;
    wradd_o <= ~a; // Released address does not keep its last value
  endtask
  // Read-port address cycle: queue select or empty-bus device select
  task automatic sel_r(input logic [5:0] a, input logic strobe);
    @(posedge clk_i);
    rdadd_o <= a;
    raden_o <= ~strobe;
    estr_o  <= strobe;
    @(posedge clk_i);
    raden_o <= 1'b0;
    estr_o  <= 1'b0;
    rdadd_o <= ~a;
  endtask
  // One full-width word; caller sets markers, no narrow lanes in x36
  task automatic put(input mqfbp_word_type w);
    @(posedge clk_i);
    wen_n_o <= 1'b0;
    din_o   <= w;
    @(posedge clk_i);
    wen_n_o <= 1'b1;
    din_o   <= ~w;
  endtask
  // Read strobe, then sample the word and valid flag one cycle later
  task automatic get(output mqfbp_word_type w, output logic ov_n);
    @(posedge clk_i);
    ren_n_o <= 1'b0;
    @(posedge clk_i);
    ren_n_o <= 1'b1;
    @(posedge clk_i);
    w    = dout_i;
    ov_n = ov_n_i;
  endtask
endmodule

// [testbench/tb.sv]
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench for the flag buses and packet handling
module tb;
  import mqfbp_pkg::*;
  logic               clk_i;
  logic               rst_i;
  logic [7:0]         adr_i;
  logic [31:0]        dat_i;
  logic [31:0]        dat_o;
  logic               we_i;
  logic               cyc_i;
  logic               stb_i;
  logic               ack_o;
  logic               straps;
  logic               tok_f;
  logic               tok_e;
  mqfbp_qaddr_type    wradd;
  mqfbp_qaddr_type    rdadd;
  logic               waden;
  logic               fstr;
  logic               wen_n;
  logic               raden;
  logic               estr;
  logic               ren_n;
  logic               ov_n;
  logic               pr_n;
  logic               ff_n;
  logic               tok_fo;
  logic               tok_eo;
  mqfbp_word_type     din;
  mqfbp_word_type     dout;
  mqfbp_flag_bus_type af_bus;
  mqfbp_flag_bus_type ae_bus;
  logic [31:0]        rd;
  mqfbp_word_type     w;
  logic               v;
  int                 num_errors;
  int                 check_count;
  // Straps all low: x36 both ports, offset 8, direct mode, device 0
  mqfbp_top mqfbp_top_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .we_i(we_i), .sel_i(4'hf), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .bus_width_select_i(straps), .input_width_select_i(straps),
    .output_width_select_i(straps), .default_offset_select_i(straps),
    .flag_bus_mode_select_i(straps), .device_id_i({3{straps}}), .wradd_i(wradd),
    .waden_i(waden), .fstr_i(fstr), .wen_n_i(wen_n), .din_i(din), .full_flag_n_o(ff_n),
    .full_bus_token_i(tok_f), .full_bus_token_o(tok_fo), .rdadd_i(rdadd), .raden_i(raden),
    .estr_i(estr), .ren_n_i(ren_n), .dout_o(dout), .output_valid_flag_n_o(ov_n),
    .packet_ready_flag_n_o(pr_n), .empty_bus_token_i(tok_e), .empty_bus_token_o(tok_eo),
    .almost_full_status_bus_o(af_bus), .almost_empty_status_bus_o(ae_bus));
  mqfbp_far_end far_i (.clk_i(clk_i), .wradd_o(wradd), .waden_o(waden), .fstr_o(fstr),
    .wen_n_o(wen_n), .din_o(din), .rdadd_o(rdadd), .raden_o(raden), .estr_o(estr),
    .ren_n_o(ren_n), .dout_i(dout), .ov_n_i(ov_n));
  // ==========================================================
  // Clock, 100 ns period
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic close_out();
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One compare task per kind of result
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_word(input logic [35:0] g, input logic [35:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_reg({31'h0, g}, {31'h0, e});
  endtask
  // ==========================================================
  // Wishbone classic master; holds the request until ack is sampled
  task automatic wb(input logic [7:0] a, input logic wr, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    adr_i <= a;
    we_i  <= wr;
    dat_i <= d;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Watchdog, well beyond the six hundred and fifty or so cycles the tests need
  initial begin
    #(5000 * 100);
    num_errors++;
    close_out();
  end
  // ==========================================================
  // Test sequence
  initial begin
    num_errors = 0;
    check_count = 0;
    rst_i = 1'b1;
    straps = 1'b0;
    tok_f = 1'b0;
    tok_e = 1'b0;
    adr_i = '0;
    dat_i = '0;
    we_i = 1'b0;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    idle(5);
    rst_i <= 1'b0;
    chk_reg({22'h0, ae_bus}, {22'h0, 8'hff, 2'b00});
    // Reset contents of the register map
    wb(`MQFBP_ADR_CTRL, 1'b0, 32'h0, rd);
    chk_reg(rd, 32'h8);
    wb(`MQFBP_ADR_OFF0, 1'b0, 32'h0, rd);
    chk_reg(rd, 32'h0808);
    wb(8'h10, 1'b1, 32'hffff, rd);
    wb(8'h10, 1'b0, 32'h0, rd);
    chk_reg(rd, 32'h0);
    // Four queues: four active outputs on the empty bus, none on the full bus
    wb(`MQFBP_ADR_CTRL, 1'b1, 32'h4, rd);
    far_i.sel_r(6'o00, 1'b1);
    far_i.sel_w(6'o00, 1'b1);
    idle(3);
    chk_bit(ae_bus.oe, 1'b1);
    chk_bit(af_bus.oe, 1'b1);
    chk_reg(ae_bus.flags_n, 8'hf0);
    chk_reg(af_bus.flags_n, 8'hff);
    // Almost-empty boundary at the default offset of 8 words
    far_i.sel_w(6'o00, 1'b0);
    for (int i = 0; i < 9; i++) begin
      if (i == 8) begin
        idle(3);
        chk_reg(ae_bus.flags_n, 8'hf0);
      end
      far_i.put({2'b00, 34'(i)});
    end
    idle(3);
    chk_reg(ae_bus.flags_n, 8'hf1);
    // Queue 2 fills: almost full at 248 words, full at 256, word 257 refused
    far_i.sel_w(6'o02, 1'b0);
    for (int i = 1; i <= 257; i++) begin
      far_i.put({2'b00, 34'(i)});
      if (i == 247 || i == 248) begin
        idle(2);
        chk_reg(af_bus.flags_n, (i == 248) ? 8'hfb : 8'hff);
      end
    end
    idle(1);
    chk_bit(ff_n, 1'b0);
    // Another device addressed: this one gives up the empty bus only
    far_i.sel_r(6'o10, 1'b1);
    idle(3);
    chk_bit(ae_bus.oe, 1'b0);
    chk_bit(af_bus.oe, 1'b1);
    far_i.sel_r(6'o00, 1'b1);
    // Packet mode: three-word packet into queue 1
    wb(`MQFBP_ADR_CTRL, 1'b1, 32'h18, rd);
    far_i.sel_w(6'o01, 1'b0);
    far_i.sel_r(6'o01, 1'b0);
    far_i.put({2'b01, 34'h1});
    far_i.put({2'b00, 34'h2});
    idle(3);
    chk_reg(ae_bus.flags_n, 8'hff);
    far_i.put({2'b10, 34'h3});
    idle(3);
    chk_reg(ae_bus.flags_n, 8'hfd);
    idle(3);
    chk_bit(pr_n, 1'b0);
    for (int i = 1; i <= 3; i++) begin
      far_i.get(w, v);
      chk_word(w, {i == 3, i == 1, 34'(i)});
      chk_bit(v, 1'b0);
    end
    idle(3);
    chk_reg(ae_bus.flags_n, 8'hff);
    chk_bit(pr_n, 1'b1);
    // ==========================================================
    // Second reset, all straps high: x9 in, x36 out, offset 128, polled, device 7
    idle(1);
    rst_i <= 1'b1;
    straps <= 1'b1;
    idle(5);
    rst_i <= 1'b0;
    wb(`MQFBP_ADR_OFF0, 1'b0, 32'h0, rd);
    chk_reg(rd, 32'h8080);
    // Packet enable has no effect while the input port is narrow
    wb(`MQFBP_ADR_CTRL, 1'b1, 32'h18, rd);
    wb(`MQFBP_ADR_STAT, 1'b0, 32'h0, rd);
    chk_reg(rd, 32'h020000ff);
    // A nine-bit word passes through queue 0 of this device
    far_i.sel_w(6'o70, 1'b0);
    far_i.sel_r(6'o70, 1'b0);
    far_i.put({2'b00, 34'h1a5});
    far_i.get(w, v);
    chk_word(w, 36'h1a5);
    chk_bit(v, 1'b0);
    // One token on each chain: one slot on the bus, then passed on
    tok_e <= 1'b1;
    tok_f <= 1'b1;
    idle(1);
    tok_e <= 1'b0;
    tok_f <= 1'b0;
    idle(1);
    chk_bit(ae_bus.sync, 1'b1);
    chk_bit(tok_eo, 1'b1);
    chk_bit(af_bus.oe, 1'b1);
    chk_bit(tok_fo, 1'b1);
    idle(1);
    chk_bit(ae_bus.oe, 1'b0);
    chk_bit(tok_fo, 1'b0);
    close_out();
  end
endmodule
